//--- csm_pkg.sv
// Package for the chip-select option match block: register map, option fields, codes.
// Assumes a single core clock and one word per register on the plain register port.
package csm_pkg;

  // Register word addresses
  localparam logic [7:0] CSM_OPT_BASE = 8'h00;
  localparam logic [7:0] CSM_BAR_BASE = 8'h10;
  localparam logic [7:0] CSM_PIN_ADDR = 8'h20;
  localparam logic [7:0] CSM_LATCH_ADDR = 8'h21;
  localparam logic [7:0] CSM_STATUS_ADDR = 8'h22;

  // Option register field positions
  localparam int CSM_MODE_BIT = 15;
  localparam int CSM_BYTE_LSB = 13;
  localparam int CSM_RW_LSB = 11;
  localparam int CSM_STROBE_ALIGN_BIT_BIT = 10;
  localparam int CSM_ACK_LSB = 6;
  localparam int CSM_SPACE_LSB = 4;
  localparam int CSM_IPL_LSB = 1;
  localparam int CSM_AUTOVECTOR_REQUEST_BIT = 0;

  // Base register layout: base in [15:3], block size code in [2:0]
  localparam int CSM_BLK_LSB = 0;
  localparam int CSM_BASE_LSB = 3;

  // Field codes
  localparam logic [1:0] CSM_BYTE_OFF = 2'h0;
  localparam logic [1:0] CSM_BYTE_LOWER = 2'h1;
  localparam logic [1:0] CSM_BYTE_UPPER = 2'h2;
  localparam logic [1:0] CSM_RW_READ = 2'h1;
  localparam logic [1:0] CSM_RW_WRITE = 2'h2;
  localparam logic [1:0] CSM_SP_CPU = 2'h0;
  localparam logic [1:0] CSM_SP_USER = 2'h1;
  localparam logic [1:0] CSM_SP_SUPV = 2'h2;
  localparam logic [1:0] CSM_SP_BOTH = 2'h3;
  localparam logic [1:0] CSM_PIN_DISCRETE = 2'h0;
  localparam logic [1:0] CSM_PIN_CS8 = 2'h2;
  localparam logic [1:0] CSM_PIN_CS16 = 2'h3;
  localparam logic [3:0] CSM_ACK_MAXWAIT = 4'hD;
  localparam logic [3:0] CSM_ACK_FAST = 4'hE;
  localparam logic [2:0] CSM_IPL_ANY = 3'h0;
  localparam logic [2:0] CSM_FC_CPU = 3'h7;
  localparam logic [3:0] CSM_IACK_TYPE = 4'hF;
  localparam logic [1:0] CSM_SIZ_BYTE = 2'h1;

  // Reset values
  localparam logic [15:0] CSM_OPT_RST = 16'h0000;
  localparam logic [15:0] CSM_OPT_BOOT_RST = 16'h7B70;
  localparam logic [15:0] CSM_BAR_RST = 16'h0000;
  localparam logic [15:0] CSM_BAR_BOOT_RST = 16'h0007;
  localparam logic [1:0] CSM_PIN_RST = 2'h3;
  localparam logic [6:0] CSM_LATCH_RST = 7'h00;

  // Latch bit 0 drives the channel holding general select 3 (channel 0 is boot)
  localparam int CSM_LATCH_CH0 = 4;
  localparam int CSM_LATCH_BITS = 7;

  // Processor bus as seen by the block
  typedef struct packed {
    logic [23:0] addr;
    logic [2:0] fc;
    logic rd;
    logic [1:0] transfer_size_code;
    logic as_n;
    logic ds_n;
  } csm_bus_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } csm_reg_req_t;

endpackage

//--- csm_chip_select.sv
// Chip-select option match: per-channel qualification, acknowledge timing, discrete latch.
// Assumes bus and strobe inputs synchronous to core_clk; slow clock sampled on core_clk for its rising edge.
//
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/10ps
module csm_chip_select
  import csm_pkg::*;
#(
  parameter int NUM_CH = 12
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Register port
  input wire csm_reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  // Processor bus
  input wire csm_bus_t bus,
  input wire logic irq_from_pin,
  input wire logic slow_peripheral_clock,
  // Select and acknowledge outputs
  output logic [NUM_CH-1:0] select_n,
  output logic transfer_ack_n,
  output logic autovector_request_n,
  output logic fast_term,
  // Discrete outputs
  output logic [CSM_LATCH_BITS-1:0] latch_output_bits,
  output logic [CSM_LATCH_BITS-1:0] latch_output_oe
);

  // Channel count the status word and latch pins can serve
  if (NUM_CH < 11 || NUM_CH > 16) begin : g_num_ch_check
    $error("NUM_CH must be 11 to 16");
  end

  typedef struct packed {
    logic [NUM_CH-1:0][15:0] opt;
    logic [NUM_CH-1:0][15:0] bar;
    logic [NUM_CH-1:0][1:0] pin;
    logic [CSM_LATCH_BITS-1:0] latch;
    logic [NUM_CH-1:0] sel;
    logic [3:0] wcnt;
    logic ack;
    logic autovector_request;
    logic fterm;
    logic slow_peripheral_clock_prev;
    logic [31:0] rdata;
  } csm_state_t;

  csm_state_t q, d;

  // Reset image of all state
  function automatic csm_state_t csm_reset_state();
    csm_state_t s;
    s = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      s.opt[i] = (i == 0) ? CSM_OPT_BOOT_RST : CSM_OPT_RST;
      s.bar[i] = (i == 0) ? CSM_BAR_BOOT_RST : CSM_BAR_RST;
      s.pin[i] = CSM_PIN_RST;
    end
    s.latch = CSM_LATCH_RST;
    return s;
  endfunction

  // Address compare under block size mask
  function automatic logic csm_addr_hit(input logic [15:0] bar, input logic [23:0] addr);
    logic [12:0] mask;
    mask = 13'h1FFF;
    case (bar[CSM_BLK_LSB +: 3])
      3'h0: mask = 13'h1FFF;
      3'h1: mask = 13'h1FFC;
      3'h2: mask = 13'h1FF8;
      3'h3: mask = 13'h1FE0;
      3'h4: mask = 13'h1FC0;
      3'h5: mask = 13'h1F80;
      3'h6: mask = 13'h1F00;
      default: mask = 13'h1E00;
    endcase
    return ((bar[15:CSM_BASE_LSB] ^ addr[23:11]) & mask) == 13'h0000;
  endfunction

  // Full match of one channel against the current access
  function automatic logic csm_match(input logic [15:0] opt, input logic [15:0] bar,
                                     input logic [1:0] pin, input csm_bus_t b);
    logic [1:0] bl;
    logic [1:0] rw;
    logic [1:0] sp;
    logic [2:0] priority_match_field;
    logic iack;
    logic lane_ok;
    logic rw_ok;
    logic sp_ok;
    logic word;
    bl = opt[CSM_BYTE_LSB +: 2];
    rw = opt[CSM_RW_LSB +: 2];
    sp = opt[CSM_SPACE_LSB +: 2];
    priority_match_field = opt[CSM_IPL_LSB +: 3];
    iack = (b.fc == CSM_FC_CPU) && (b.addr[19:16] == CSM_IACK_TYPE);
    word = (b.transfer_size_code != CSM_SIZ_BYTE) && !b.addr[0];
    if (pin == CSM_PIN_CS16) begin
      // lanes against address bit 0 and size
      case (bl)
        CSM_BYTE_LOWER: lane_ok = b.addr[0] || word;
        CSM_BYTE_UPPER: lane_ok = !b.addr[0];
        CSM_BYTE_OFF: lane_ok = 1'b0;
        default: lane_ok = 1'b1;
      endcase
    end else begin
      lane_ok = (bl != CSM_BYTE_OFF);
    end
    case (rw)
      CSM_RW_READ: rw_ok = b.rd;
      CSM_RW_WRITE: rw_ok = !b.rd;
      2'h3: rw_ok = 1'b1;
      default: rw_ok = 1'b0;
    endcase
    case (sp)
      CSM_SP_USER: sp_ok = !b.fc[2] && (b.fc[1:0] != 2'h0) && (b.fc[1:0] != 2'h3);
      CSM_SP_SUPV: sp_ok = b.fc[2] && (b.fc[1:0] != 2'h0) && (b.fc[1:0] != 2'h3);
      CSM_SP_BOTH: sp_ok = (b.fc[1:0] != 2'h0) && (b.fc[1:0] != 2'h3);
      default: sp_ok = (b.fc == CSM_FC_CPU) &&
                       (!iack || priority_match_field == CSM_IPL_ANY || priority_match_field == b.addr[3:1]);
    endcase
    return lane_ok && rw_ok && sp_ok && csm_addr_hit(bar, b.addr);
  endfunction

  logic [NUM_CH-1:0] hit;
  logic slow_peripheral_clock_rise;
  logic is_iack;

  assign slow_peripheral_clock_rise = slow_peripheral_clock && !q.slow_peripheral_clock_prev;
  assign is_iack = (bus.fc == CSM_FC_CPU) && (bus.addr[19:16] == CSM_IACK_TYPE);

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      hit[i] = csm_match(q.opt[i], q.bar[i], q.pin[i], bus);
    end
  end

  always_comb begin
    logic found;
    logic [15:0] o;
    found = 1'b0;
    o = '0;
    d = q;
    d.rdata = '0;
    d.slow_peripheral_clock_prev = slow_peripheral_clock;

    // Register writes
    if (reg_req.wr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_req.addr == CSM_OPT_BASE + 8'(i)) begin
          d.opt[i] = reg_req.wdata;
        end
        if (reg_req.addr == CSM_BAR_BASE + 8'(i)) begin
          d.bar[i] = reg_req.wdata;
        end
      end
      if (reg_req.addr == CSM_PIN_ADDR) begin
        for (int i = 0; i < NUM_CH && i < 8; i++) begin
          d.pin[i] = reg_req.wdata[2*i +: 2];
        end
      end
      if (reg_req.addr == CSM_LATCH_ADDR) begin
        d.latch = reg_req.wdata[CSM_LATCH_BITS-1:0];
      end
    end

    // Register reads
    if (reg_req.rd) begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (reg_req.addr == CSM_OPT_BASE + 8'(i)) begin
          d.rdata = {16'h0000, q.opt[i]};
        end
        if (reg_req.addr == CSM_BAR_BASE + 8'(i)) begin
          d.rdata = {16'h0000, q.bar[i]};
        end
        if (reg_req.addr == CSM_PIN_ADDR) begin
          d.rdata[2*i +: 2] = q.pin[i];
        end
      end
      if (reg_req.addr == CSM_LATCH_ADDR) begin
        d.rdata = {25'h0, q.latch};
      end
      if (reg_req.addr == CSM_STATUS_ADDR) begin
        d.rdata = {q.ack, q.autovector_request, q.fterm, 13'h0000, 16'(q.sel)};
      end
    end

    // Bus cycle tracking
    if (bus.as_n) begin
      // selects drop with the address strobe
      d.sel = '0;
      d.wcnt = '0;
      d.ack = 1'b0;
      d.autovector_request = 1'b0;
      d.fterm = 1'b0;
    end else begin
      if (q.wcnt != 4'hF) begin
        d.wcnt = q.wcnt + 4'h1;
      end
      for (int i = 0; i < NUM_CH; i++) begin
        if (hit[i] && !q.sel[i]) begin
          if (!q.opt[i][CSM_MODE_BIT]) begin
            d.sel[i] = q.opt[i][CSM_STROBE_ALIGN_BIT_BIT] ? !bus.ds_n : 1'b1;
          end else begin
            d.sel[i] = slow_peripheral_clock_rise;
          end
        end
      end
      // Lowest matching asynchronous channel owns the acknowledge
      for (int i = NUM_CH - 1; i >= 0; i--) begin
        if (hit[i] && !q.opt[i][CSM_MODE_BIT]) begin
          found = 1'b1;
          o = q.opt[i];
        end
      end
      if (found && !q.ack && !q.autovector_request) begin
        if (o[CSM_ACK_LSB +: 4] == CSM_ACK_FAST) begin
          d.fterm = 1'b1;
          d.ack = 1'b1;
        end else if (o[CSM_ACK_LSB +: 4] <= CSM_ACK_MAXWAIT &&
                     q.wcnt >= o[CSM_ACK_LSB +: 4]) begin
          if (o[CSM_AUTOVECTOR_REQUEST_BIT] && is_iack && irq_from_pin) begin
            d.autovector_request = 1'b1;
          end else begin
            d.ack = 1'b1;
          end
        end
      end
    end
  end

  // byte lanes: general cleared, boot both
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      q <= csm_reset_state();
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign transfer_ack_n = !q.ack;
  assign autovector_request_n = !q.autovector_request;
  assign fast_term = q.fterm;

  // active-low selects on chip-select pins only
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      select_n[i] = !(q.sel[i] && q.pin[i][1]);
    end
  end

  always_comb begin
    for (int i = 0; i < CSM_LATCH_BITS; i++) begin
      latch_output_bits[i] = q.latch[i];
      latch_output_oe[i] = (q.pin[CSM_LATCH_CH0 + i] == CSM_PIN_DISCRETE);
    end
  end

  function automatic logic found_async_hit();
    logic f;
    f = 1'b0;
    for (int i = 0; i < NUM_CH; i++) begin
      f = f || (hit[i] && !q.opt[i][CSM_MODE_BIT]);
    end
    return f;
  endfunction

  // Assertions
  AST_SEL_DROP: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus.as_n |=> (q.sel == '0))
    else $error("select held after address strobe negated");

  AST_BOOT_RESET: assert property (@(posedge core_clk)
    !reset_n |=> (q.opt[0][CSM_BYTE_LSB +: 2] == 2'h3 && q.opt[1][CSM_BYTE_LSB +: 2] == 2'h0))
    else $error("byte lane reset values wrong");

  AST_NO_ACK_SYNC: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!bus.as_n && $rose(q.ack) && !q.fterm) |->
      $past(found_async_hit()))
    else $error("internal ack without asynchronous match");

  AST_WAIT_COUNT: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(q.ack) && !q.fterm |-> $past(q.wcnt) <= CSM_ACK_MAXWAIT)
    else $error("ack beyond maximum wait count");

  AST_FAST: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!bus.as_n && hit[1] && !hit[0] && !q.opt[1][CSM_MODE_BIT] && !q.ack && !q.autovector_request &&
     q.opt[1][CSM_ACK_LSB +: 4] == CSM_ACK_FAST) |=> q.ack && q.fterm)
    else $error("fast termination not given");

  AST_DISABLED: assert property (@(posedge core_clk) disable iff (!reset_n)
    (q.opt[1][CSM_BYTE_LSB +: 2] == CSM_BYTE_OFF) |-> !hit[1])
    else $error("disabled channel matched");

  AST_RW_RSVD: assert property (@(posedge core_clk) disable iff (!reset_n)
    (q.opt[1][CSM_RW_LSB +: 2] == 2'h0) |-> !hit[1])
    else $error("reserved read/write code matched");

  AST_LATCH7: assert property (@(posedge core_clk) disable iff (!reset_n)
    (reg_req.rd && reg_req.addr == CSM_LATCH_ADDR) |=> reg_rdata[31:7] == 25'h0)
    else $error("latch bit 7 read nonzero");

  AST_EXT_WAIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!bus.as_n && hit[1] && !hit[0] && !q.opt[1][CSM_MODE_BIT] && !q.ack &&
     q.opt[1][CSM_ACK_LSB +: 4] == 4'hF) |=> !q.ack)
    else $error("internal ack with external code");

  AST_SYNC_EDGE: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!bus.as_n && !q.sel[1] && q.opt[1][CSM_MODE_BIT] && !slow_peripheral_clock_rise) |=> !q.sel[1])
    else $error("synchronous select off the slow clock edge");

  AST_SYNC_NO_ACK: assert property (@(posedge core_clk) disable iff (!reset_n)
    (!bus.as_n && !q.ack && !found_async_hit()) |=> !q.ack)
    else $error("internal ack without asynchronous channel");

  AST_ACK_DROP: assert property (@(posedge core_clk) disable iff (!reset_n)
    bus.as_n |=> (!q.ack && !q.autovector_request && !q.fterm))
    else $error("acknowledge held after address strobe negated");

  AST_AUTOVECTOR_REQUEST_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(q.autovector_request) |-> $past(irq_from_pin) && $past(is_iack))
    else $error("autovector for a request not from a pin");

  AST_IPL_MISS: assert property (@(posedge core_clk) disable iff (!reset_n)
    (is_iack && q.opt[1][CSM_SPACE_LSB +: 2] == CSM_SP_CPU &&
     q.opt[1][CSM_IPL_LSB +: 3] != CSM_IPL_ANY &&
     q.opt[1][CSM_IPL_LSB +: 3] != bus.addr[3:1]) |-> !hit[1])
    else $error("select matched another priority");

  AST_LOWER_LANE: assert property (@(posedge core_clk) disable iff (!reset_n)
    (q.pin[1] == CSM_PIN_CS16 && q.opt[1][CSM_BYTE_LSB +: 2] == CSM_BYTE_LOWER &&
     !bus.addr[0] && bus.transfer_size_code == CSM_SIZ_BYTE) |-> !hit[1])
    else $error("lower lane matched an even byte");

endmodule

//--- csm_ext_device.sv
// Model of an external peripheral that sits on the chip selects.
// Assumes selects and address strobe are synchronous to core_clk.
`timescale 1ns/10ps
module csm_ext_device
  import csm_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Selects from the block, address strobe from the bus
  input wire logic [11:0] select_n,
  input wire logic as_n,
  // Peripheral answer
  output logic ext_ack_n,
  output int n_select
);
  logic [11:0] sel_q;
  logic [1:0] wait_q;
  initial begin
    sel_q = '1;
    wait_q = 2'h0;
    ext_ack_n = 1'b1;
    n_select = 0;
  end
  // answers a selected cycle after two waits
  always @(posedge core_clk) begin
    sel_q <= select_n;
    if ((sel_q & ~select_n) != 12'h000) begin
      n_select <= n_select + 1;
    end
    if (as_n) begin
      wait_q <= 2'h0;
      ext_ack_n <= 1'b1;
    end else if (select_n != 12'hFFF) begin
      if (wait_q == 2'h2) begin
        ext_ack_n <= 1'b0;
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

//--- chip_select_option_match_bench.sv
// Self-checking bench for the chip-select option match block.
// Assumes csm_pkg register map and a 40 MHz core clock.
`timescale 1ns/10ps
module chip_select_option_match_bench;
  import csm_pkg::*;
  logic core_clk, reset_n, irq_from_pin, slow_peripheral_clock;
  csm_reg_req_t reg_req;
  csm_bus_t bus;
  logic [31:0] reg_rdata;
  logic [11:0] select_n;
  logic transfer_ack_n, autovector_request_n, fast_term, ext_ack_n;
  logic [6:0] latch_output_bits, latch_output_oe;
  int n_mismatch, n_compared, cyc, n_select;

  csm_chip_select u_csm_chip_select (.core_clk(core_clk), .reset_n(reset_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .bus(bus), .irq_from_pin(irq_from_pin),
    .slow_peripheral_clock(slow_peripheral_clock), .select_n(select_n),
    .transfer_ack_n(transfer_ack_n), .autovector_request_n(autovector_request_n),
    .fast_term(fast_term), .latch_output_bits(latch_output_bits),
    .latch_output_oe(latch_output_oe));
  csm_ext_device u_csm_ext_device (.core_clk(core_clk), .select_n(select_n),
    .as_n(bus.as_n), .ext_ack_n(ext_ack_n), .n_select(n_select));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 chk("register", exp, reg_rdata);
  endtask

  task automatic bus_go(input logic [23:0] a, input logic [2:0] fc, input logic rd,
                        input logic [1:0] transfer_size_code, input logic ds);
    @(posedge core_clk);
    bus <= '{addr: a, fc: fc, rd: rd, transfer_size_code: transfer_size_code, as_n: 1'b0, ds_n: ds};
  endtask

  task automatic bus_end();
    @(posedge core_clk);
    bus.as_n <= 1'b1;
    bus.ds_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk("selects idle", 32'h00000FFF, {20'h0, select_n});
  endtask

  task automatic sel_chk(input logic [23:0] a, input logic [2:0] fc, input logic rd,
                         input logic [1:0] transfer_size_code, input logic exp);
    int n0;
    n0 = n_select;
    bus_go(a, fc, rd, transfer_size_code, 1'b0);
    repeat (3) @(posedge core_clk);
    #1 chk("select 1", {31'h0, ~exp}, {31'h0, select_n[1]});
    chk("select count", {31'h0, exp}, n_select - n0);
    bus_end();
  endtask

  task automatic ack_time(input logic [3:0] code);
    int found;
    int exp;
    found = -1;
    exp = (code == 4'hF) ? -1 : ((code == 4'hE) ? 1 : int'(code) + 1);
    reg_write(CSM_OPT_BASE + 8'h01, 16'h7830 | {6'h00, code, 6'h00});
    bus_go(24'h100000, 3'h5, 1'b1, 2'h2, 1'b0);
    for (int n = 1; n <= 20; n++) begin
      @(posedge core_clk);
      #1;
      if (found < 0 && transfer_ack_n === 1'b0) begin
        found = n;
        chk("fast term", {31'h0, code == 4'hE}, {31'h0, fast_term});
      end
    end
    chk("ack delay", exp, found);
    if (code == 4'hF) begin
      chk("external ack", 32'h0, {31'h0, ext_ack_n});
    end
    bus_end();
  endtask

  task automatic test_reset();
    reg_check(CSM_OPT_BASE, {16'h0, CSM_OPT_BOOT_RST});
    reg_check(CSM_OPT_BASE + 8'h01, 32'h0);
    reg_check(CSM_BAR_BASE, 32'h00000007);
    reg_check(8'h40, 32'h0);
    sel_chk(24'h100000, 3'h5, 1'b1, 2'h2, 1'b0);
    bus_go(24'h000000, 3'h6, 1'b1, 2'h2, 1'b0);
    repeat (3) @(posedge core_clk);
    #1 chk("boot select", 32'h0, {31'h0, select_n[0]});
    chk("boot ack wait", 32'h1, {31'h0, transfer_ack_n});
    bus_end();
  endtask

  task automatic test_lanes();
    reg_write(CSM_BAR_BASE + 8'h01, 16'h1007);
    reg_write(CSM_OPT_BASE + 8'h01, 16'h5830);
    sel_chk(24'h100000, 3'h5, 1'b1, 2'h1, 1'b1);
    sel_chk(24'h100001, 3'h5, 1'b1, 2'h1, 1'b0);
    sel_chk(24'h100000, 3'h1, 1'b0, 2'h2, 1'b1);
    reg_write(CSM_PIN_ADDR, 16'hFFFB);
    sel_chk(24'h100001, 3'h5, 1'b1, 2'h1, 1'b1);
    reg_write(CSM_PIN_ADDR, 16'hFFFF);
    reg_write(CSM_OPT_BASE + 8'h01, 16'h3830);
    sel_chk(24'h100000, 3'h5, 1'b1, 2'h1, 1'b0);
    sel_chk(24'h100001, 3'h5, 1'b1, 2'h1, 1'b1);
    sel_chk(24'h100000, 3'h5, 1'b1, 2'h2, 1'b1);
  endtask

  task automatic test_rw();
    reg_write(CSM_OPT_BASE + 8'h01, 16'h7030);
    sel_chk(24'h100000, 3'h5, 1'b1, 2'h2, 1'b0);
    sel_chk(24'h100000, 3'h5, 1'b0, 2'h2, 1'b1);
    reg_write(CSM_OPT_BASE + 8'h01, 16'h6820);
    sel_chk(24'h100000, 3'h5, 1'b1, 2'h2, 1'b1);
    sel_chk(24'h100000, 3'h1, 1'b1, 2'h2, 1'b0);
  endtask

  task automatic iack(input logic [15:0] opt, input logic [23:0] a, input logic exp);
    reg_write(CSM_OPT_BASE + 8'h01, opt);
    bus_go(a, 3'h7, 1'b1, 2'h1, 1'b0);
    repeat (3) @(posedge core_clk);
    #1 chk("iack select", {31'h0, ~exp}, {31'h0, select_n[1]});
    chk("autovector", {31'h0, ~exp}, {31'h0, autovector_request_n});
    bus_end();
  endtask

  task automatic iack_internal();
    @(posedge core_clk);
    irq_from_pin <= 1'b0;
    bus_go(24'hFFFFF7, 3'h7, 1'b1, 2'h1, 1'b0);
    repeat (3) @(posedge core_clk);
    #1 chk("internal autovector", 32'h1, {31'h0, autovector_request_n});
    bus_end();
    @(posedge core_clk);
    irq_from_pin <= 1'b1;
  endtask

  task automatic test_strobes();
    reg_write(CSM_OPT_BASE + 8'h01, 16'h7C30);
    bus_go(24'h100000, 3'h5, 1'b1, 2'h2, 1'b1);
    repeat (3) @(posedge core_clk);
    #1 chk("ds wait", 32'h1, {31'h0, select_n[1]});
    @(posedge core_clk);
    bus.ds_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk("ds select", 32'h0, {31'h0, select_n[1]});
    bus_end();
    reg_write(CSM_OPT_BASE + 8'h01, 16'hF830);
    bus_go(24'h100000, 3'h5, 1'b1, 2'h2, 1'b0);
    repeat (4) @(posedge core_clk);
    #1 chk("sync wait", 32'h1, {31'h0, select_n[1]});
    @(posedge core_clk);
    slow_peripheral_clock <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 chk("sync select", 32'h0, {31'h0, select_n[1]});
    chk("sync ack", 32'h1, {31'h0, transfer_ack_n});
    @(posedge core_clk);
    slow_peripheral_clock <= 1'b0;
    bus_end();
  endtask

  task automatic test_latch();
    reg_write(CSM_LATCH_ADDR, 16'h00FF);
    reg_check(CSM_LATCH_ADDR, 32'h0000007F);
    reg_write(CSM_PIN_ADDR, 16'hFCFF);
    @(posedge core_clk);
    #1 chk("latch pin", 32'h3, {30'h0, latch_output_oe[0], latch_output_bits[0]});
  endtask

  initial begin
    n_mismatch = 0;
    n_compared = 0;
    cyc = 0;
    reset_n = 1'b0;
    irq_from_pin = 1'b1;
    slow_peripheral_clock = 1'b0;
    reg_req = '0;
    bus = '{addr: 24'h0, fc: 3'h0, rd: 1'b1, transfer_size_code: 2'h2, as_n: 1'b1, ds_n: 1'b1};
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    test_reset();
    test_lanes();
    test_rw();
    ack_time(4'h0);
    ack_time(4'h3);
    ack_time(4'hD);
    ack_time(4'hE);
    ack_time(4'hF);
    reg_write(CSM_BAR_BASE + 8'h01, 16'hFFFB);
    iack(16'h6807, 24'hFFFFF7, 1'b1);
    iack(16'h6807, 24'hFFFFFB, 1'b0);
    iack(16'h6801, 24'hFFFFFB, 1'b1);
    iack_internal();
    reg_write(CSM_BAR_BASE + 8'h01, 16'h1007);
    test_strobes();
    test_latch();
    wrap_up();
  end
endmodule
